// ===== tsrb_defines.vh
// Purpose: shared constants of the temperature sensor register bank
// Assumes: included by its bare name
// Notes: times in ms, clock rate in kHz, so ms * kHz gives cycles
`ifndef TSRB_DEFINES_VH
`define TSRB_DEFINES_VH
`define TSRB_PTR_RESULT 2'h0
`define TSRB_PTR_CONFIG 2'h1
`define TSRB_PTR_LOW 2'h2
`define TSRB_PTR_HIGH 2'h3
`define TSRB_CFG_ALERT 5
`define TSRB_CFG_RATE_LO 6
`define TSRB_CFG_RATE_HI 7
`define TSRB_CFG_SLEEP 8
`define TSRB_CFG_IRQ 9
`define TSRB_CFG_POL 10
`define TSRB_CFG_FAULT_LO 11
`define TSRB_CFG_FAULT_HI 12
`define TSRB_CFG_RSVD_ONE 14
`define TSRB_PTR_RESET 2'h0
`define TSRB_RATE_RESET 2'h2
`define TSRB_FAULT_RESET 2'h0
`define TSRB_LOW_RESET 16'h0800
`define TSRB_HIGH_RESET 16'h1000
`define TSRB_DEV_ADDR 7'h40
`define TSRB_CLK_KHZ 125000
`define TSRB_CONV_TIME_MS 36
`define TSRB_PERIOD_Q_MS 4000
`define TSRB_PERIOD_1_MS 1000
`define TSRB_PERIOD_4_MS 250
`define TSRB_PERIOD_8_MS 125
`endif

// ===== tsrb_conv.v
// Purpose: conversion timebase, result capture and alert state
// Assumes: temp_sample is the converter output on clk_sys
// Notes: period must exceed conversion time, so start and end never meet
`timescale 1ns/100ps
`include "tsrb_defines.vh"
module tsrb_conv #(
   parameter [31:0] CONV_CYCLES = `TSRB_CONV_TIME_MS * `TSRB_CLK_KHZ,
   parameter [31:0] PERIOD_Q = `TSRB_PERIOD_Q_MS * `TSRB_CLK_KHZ,
   parameter [31:0] PERIOD_1 = `TSRB_PERIOD_1_MS * `TSRB_CLK_KHZ,
   parameter [31:0] PERIOD_4 = `TSRB_PERIOD_4_MS * `TSRB_CLK_KHZ,
   parameter [31:0] PERIOD_8 = `TSRB_PERIOD_8_MS * `TSRB_CLK_KHZ
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire sleep_ctrl,
   input wire [1:0] conversion_rate_sel,
   input wire [1:0] fault_count_sel,
   input wire alert_polarity,
   input wire irq_style_sel,
   input wire [15:0] low_temp_threshold,
   input wire [15:0] high_temp_threshold,
   input wire [15:0] temp_sample,
   input wire irq_clear,
   output reg [15:0] temperature_result,
   output wire alert_flag,
   output reg alert_oe_n
);
   reg busy;
   reg sleep_d;
   reg fault;
   reg irq_latch;
   reg [31:0] conv_cnt;
   reg [31:0] per_cnt;
   reg [2:0] run;
   reg next_fault;
   wire conv_done = busy && (conv_cnt == CONV_CYCLES - 32'h1);
   wire over = $signed(temp_sample) > $signed(high_temp_threshold);
   wire under = $signed(temp_sample) < $signed(low_temp_threshold);
   wire [2:0] need = {1'b0, fault_count_sel} + 3'h1;
   wire asserted = irq_style_sel ? irq_latch : fault;

   function [31:0] period_of;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: period_of = PERIOD_Q;
            2'h1: period_of = PERIOD_1;
            2'h2: period_of = PERIOD_4;
            default: period_of = PERIOD_8;
         endcase
      end
   endfunction

   assign alert_flag = alert_polarity ? fault : ~fault;

   always @* begin
      next_fault = fault;
      if (conv_done && (fault ? under : over) && (run + 3'h1 == need)) begin
         next_fault = ~fault;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         busy <= 1'b1;
         sleep_d <= 1'b0;
         conv_cnt <= 32'h0;
         per_cnt <= 32'h0;
         temperature_result <= 16'h0000;
         fault <= 1'b0;
         run <= 3'h0;
         irq_latch <= 1'b0;
         alert_oe_n <= 1'b1;
      end else if (ce) begin
         sleep_d <= sleep_ctrl;
         fault <= next_fault;
         // open drain: pulled low when the wanted level is low
         alert_oe_n <= ~(asserted ^ alert_polarity);
         // set wins over a host read clearing it
         if (irq_style_sel && (next_fault != fault)) begin
            irq_latch <= 1'b1;
         end else if (irq_clear || !irq_style_sel) begin
            irq_latch <= 1'b0;
         end
         if (conv_done) begin
            temperature_result <= temp_sample;
            if (next_fault != fault) begin
               run <= 3'h0;
            end else if (fault ? under : over) begin
               run <= run + 3'h1;
            end else begin
               run <= 3'h0;
            end
         end
         if (sleep_ctrl) begin
            busy <= 1'b0;
            per_cnt <= 32'h0;
            conv_cnt <= 32'h0;
         end else if (sleep_d || per_cnt >= period_of(conversion_rate_sel) - 32'h1) begin
            busy <= 1'b1;
            per_cnt <= 32'h0;
            conv_cnt <= 32'h0;
         end else begin
            per_cnt <= per_cnt + 32'h1;
            if (conv_done) begin
               busy <= 1'b0;
            end else if (busy) begin
               conv_cnt <= conv_cnt + 32'h1;
            end
         end
      end
   end
endmodule

// ===== tsrb_top.v
// Purpose: register bank of a temperature sensor behind a two-wire slave
// Assumes: scl_in and sda_in are asynchronous pins, sampled on clk_sys
// Notes: scl must stay below an eighth of clk_sys for clean edge finding
`timescale 1ns/100ps
`include "tsrb_defines.vh"
module tsrb_top #(
   parameter [6:0] DEV_ADDR = `TSRB_DEV_ADDR,
   parameter [31:0] CONV_CYCLES = `TSRB_CONV_TIME_MS * `TSRB_CLK_KHZ,
   parameter [31:0] PERIOD_Q = `TSRB_PERIOD_Q_MS * `TSRB_CLK_KHZ,
   parameter [31:0] PERIOD_1 = `TSRB_PERIOD_1_MS * `TSRB_CLK_KHZ,
   parameter [31:0] PERIOD_4 = `TSRB_PERIOD_4_MS * `TSRB_CLK_KHZ,
   parameter [31:0] PERIOD_8 = `TSRB_PERIOD_8_MS * `TSRB_CLK_KHZ
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe_n,
   input wire [15:0] temp_sample,
   output wire alert_out,
   output wire alert_oe_n
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_ACK = 3'h2;
   localparam [2:0] ST_WRITE = 3'h3;
   localparam [2:0] ST_READ = 3'h4;
   localparam [2:0] ST_RACK = 3'h5;
   localparam [2:0] ST_RLOAD = 3'h6;

   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg scl_prev;
   reg sda_prev;
   reg [2:0] state;
   reg [2:0] bit_cnt;
   reg byte_full;
   reg [1:0] byte_no;
   reg [7:0] shift;
   reg [7:0] wr_msb;
   reg [7:0] tx;
   reg [15:0] rd_word;
   reg rd_lsb;
   reg rw;
   reg irq_clear;
   reg [1:0] ptr;
   reg [1:0] conversion_rate_sel;
   reg sleep_ctrl;
   reg irq_style_sel;
   reg alert_polarity;
   reg [1:0] fault_count_sel;
   reg [15:0] low_temp_threshold;
   reg [15:0] high_temp_threshold;
   wire [15:0] temperature_result;
   wire alert_flag;
   wire [15:0] cur_word;
   wire [7:0] register_pointer;
   wire [15:0] wr_word;

   wire scl = scl_sync[1];
   wire sda = sda_sync[1];
   wire scl_rise = scl && !scl_prev;
   wire scl_fall = !scl && scl_prev;
   wire start_det = scl && scl_prev && sda_prev && !sda;
   wire stop_det = scl && scl_prev && !sda_prev && sda;

   assign register_pointer = {6'h00, ptr};
   assign wr_word = {wr_msb, shift};
   assign sda_out = 1'b0;
   assign alert_out = 1'b0;

   function [15:0] sel_word;
      input [1:0] p;
      input [15:0] res;
      input [15:0] cfg;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if (p == `TSRB_PTR_RESULT) begin
            sel_word = res;
         end else if (p == `TSRB_PTR_CONFIG) begin
            sel_word = cfg;
         end else if (p == `TSRB_PTR_LOW) begin
            sel_word = lo;
         end else begin
            sel_word = hi;
         end
      end
   endfunction

   wire [15:0] cfg_word = {1'b0, 1'b1, 1'b0, fault_count_sel, alert_polarity,
                           irq_style_sel, sleep_ctrl, conversion_rate_sel,
                           alert_flag, 5'h00};

   assign cur_word = sel_word(ptr, temperature_result, cfg_word,
                              low_temp_threshold, high_temp_threshold);

   // the first stage feeds only the second
   always @(posedge clk_sys) begin
      if (rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else if (ce) begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
      end
   end

   // word goes high byte first; snapshot taken with the high byte
   task load_byte;
      begin
         bit_cnt <= 3'h0;
         rd_lsb <= ~rd_lsb;
         if (!rd_lsb) begin
            rd_word <= cur_word;
            tx <= cur_word[15:8];
            sda_oe_n <= cur_word[15];
         end else begin
            tx <= rd_word[7:0];
            sda_oe_n <= rd_word[7];
         end
      end
   endtask

   always @(posedge clk_sys) begin
      if (rst) begin
         state <= ST_IDLE;
         bit_cnt <= 3'h0;
         byte_full <= 1'b0;
         byte_no <= 2'h0;
         shift <= 8'h00;
         wr_msb <= 8'h00;
         tx <= 8'h00;
         rd_word <= 16'h0000;
         rd_lsb <= 1'b0;
         rw <= 1'b0;
         irq_clear <= 1'b0;
         sda_oe_n <= 1'b1;
         ptr <= `TSRB_PTR_RESET;
         conversion_rate_sel <= `TSRB_RATE_RESET;
         sleep_ctrl <= 1'b0;
         irq_style_sel <= 1'b0;
         alert_polarity <= 1'b0;
         fault_count_sel <= `TSRB_FAULT_RESET;
         low_temp_threshold <= `TSRB_LOW_RESET;
         high_temp_threshold <= `TSRB_HIGH_RESET;
      end else if (ce) begin
         irq_clear <= 1'b0;
         if (start_det) begin
            state <= ST_ADDR;
            bit_cnt <= 3'h0;
            byte_full <= 1'b0;
            byte_no <= 2'h0;
            rd_lsb <= 1'b0;
            sda_oe_n <= 1'b1;
         end else if (stop_det) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (state)
               ST_ADDR, ST_WRITE: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda};
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7) begin
                        byte_full <= 1'b1;
                     end
                  end else if (scl_fall && byte_full) begin
                     byte_full <= 1'b0;
                     if (state == ST_ADDR) begin
                        if (shift[7:1] == DEV_ADDR) begin
                           rw <= shift[0];
                           irq_clear <= shift[0];
                           sda_oe_n <= 1'b0;
                           state <= ST_ACK;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else begin
                        sda_oe_n <= 1'b0;
                        state <= ST_ACK;
                        if (byte_no != 2'h3) begin
                           byte_no <= byte_no + 2'h1;
                        end
                        if (byte_no == 2'h0) begin
                           ptr <= shift[1:0];
                        end else if (byte_no == 2'h1) begin
                           wr_msb <= shift;
                        end else if (byte_no == 2'h2) begin
                           if (ptr == `TSRB_PTR_CONFIG) begin
                              conversion_rate_sel <= wr_word[`TSRB_CFG_RATE_HI:`TSRB_CFG_RATE_LO];
                              sleep_ctrl <= wr_word[`TSRB_CFG_SLEEP];
                              irq_style_sel <= wr_word[`TSRB_CFG_IRQ];
                              alert_polarity <= wr_word[`TSRB_CFG_POL];
                              fault_count_sel <= wr_word[`TSRB_CFG_FAULT_HI:`TSRB_CFG_FAULT_LO];
                           end else if (ptr == `TSRB_PTR_LOW) begin
                              low_temp_threshold <= wr_word;
                           end else if (ptr == `TSRB_PTR_HIGH) begin
                              high_temp_threshold <= wr_word;
                           end
                        end
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 3'h0;
                     if (rw) begin
                        load_byte;
                        state <= ST_READ;
                     end else begin
                        sda_oe_n <= 1'b1;
                        state <= ST_WRITE;
                     end
                  end
               end
               ST_READ: begin
                  if (scl_fall) begin
                     if (bit_cnt == 3'h7) begin
                        // release for the host acknowledge
                        sda_oe_n <= 1'b1;
                        state <= ST_RACK;
                     end else begin
                        tx <= {tx[6:0], 1'b0};
                        sda_oe_n <= tx[6];
                        bit_cnt <= bit_cnt + 3'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     // a nack ends the read; wait for stop
                     if (sda) begin
                        state <= ST_IDLE;
                     end else begin
                        state <= ST_RLOAD;
                     end
                  end
               end
               ST_RLOAD: begin
                  if (scl_fall) begin
                     load_byte;
                     state <= ST_READ;
                  end
               end
               default: begin
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   tsrb_conv #(
      .CONV_CYCLES(CONV_CYCLES),
      .PERIOD_Q(PERIOD_Q),
      .PERIOD_1(PERIOD_1),
      .PERIOD_4(PERIOD_4),
      .PERIOD_8(PERIOD_8)
   ) u_conv (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .sleep_ctrl(sleep_ctrl),
      .conversion_rate_sel(conversion_rate_sel),
      .fault_count_sel(fault_count_sel),
      .alert_polarity(alert_polarity),
      .irq_style_sel(irq_style_sel),
      .low_temp_threshold(low_temp_threshold),
      .high_temp_threshold(high_temp_threshold),
      .temp_sample(temp_sample),
      .irq_clear(irq_clear),
      .temperature_result(temperature_result),
      .alert_flag(alert_flag),
      .alert_oe_n(alert_oe_n)
   );
endmodule

// ===== tsrb_properties.sv
// Purpose: port-level checks of the register bank's serial and alert pins
// Assumes: scl_in and sda_in are the resolved line levels
// Notes: only pins are visible, so checks tie pin drive to bus events
`timescale 1ns/100ps
module tsrb_checker (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe_n,
   input wire [15:0] temp_sample,
   input wire alert_out,
   input wire alert_oe_n
);
   reg [4:0] scl_high_cnt;
   // a long high clock only happens while the bus is idle or framing
   always @(posedge clk_sys) begin
      if (rst || !scl_in)
         scl_high_cnt <= 5'h00;
      else if (scl_high_cnt != 5'h1f)
         scl_high_cnt <= scl_high_cnt + 5'h01;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_start;
      scl_in && $fell(sda_in);
   endsequence
   sequence s_stop;
      scl_in && $rose(sda_in);
   endsequence
   chk_sda_open_drain: assert property (sda_out == 1'b0)
      else $error("data pin drives a high level");
   chk_alert_open_drain: assert property (alert_out == 1'b0)
      else $error("alert pin drives a high level");
   chk_reset_release: assert property (disable iff (1'b0) rst && ce |=> sda_oe_n && alert_oe_n)
      else $error("pins not released by reset");
   chk_freeze_hold: assert property (!ce |=> $stable(sda_oe_n) && $stable(alert_oe_n))
      else $error("pin drive moved while clock enable low");
   chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !$past(scl_in) && !$past(scl_in, 2))
      else $error("data drive changed near a high clock");
   chk_idle_release: assert property (scl_high_cnt >= 5'h0c |-> sda_oe_n)
      else $error("data held low on an idle bus");
   chk_start_release: assert property (s_start |-> sda_oe_n [*4])
      else $error("data driven after a start");
   chk_stop_release: assert property (s_stop |-> sda_oe_n ##1 $stable(sda_oe_n) [*3])
      else $error("data driven after a stop");
endmodule
bind tsrb_top tsrb_checker u_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .temp_sample(temp_sample), .alert_out(alert_out),
   .alert_oe_n(alert_oe_n));

// ===== tsrb_host_model.sv
// Purpose: two-wire host that loads the pointer and moves register words
// Assumes: sda_in is the wired level with a pull-up
// Notes: clock half period is 4 system clocks, giving a 64 ns bit
`timescale 1ns/100ps
module tsrb_host_model #(
   parameter [6:0] ADDR = 7'h40
) (
   input wire clk_sys,
   input wire sda_in,
   output reg scl,
   output reg sda_oe_n
);
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end
   task tick;
      input integer n;
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task put_bit;
      input b;
      begin
         sda_oe_n = b;
         tick(2);
         scl = 1'b1;
         tick(4);
         scl = 1'b0;
         tick(2);
      end
   endtask
   task get_bit;
      output b;
      begin
         sda_oe_n = 1'b1;
         tick(2);
         scl = 1'b1;
         tick(2);
         b = sda_in;
         tick(2);
         scl = 1'b0;
         tick(2);
      end
   endtask
   task start_cond;
      begin
         sda_oe_n = 1'b1;
         tick(2);
         scl = 1'b1;
         tick(4);
         sda_oe_n = 1'b0;
         tick(4);
         scl = 1'b0;
         tick(2);
      end
   endtask
   task stop_cond;
      begin
         sda_oe_n = 1'b0;
         tick(2);
         scl = 1'b1;
         tick(4);
         sda_oe_n = 1'b1;
         tick(4);
      end
   endtask
   task put_byte;
      input [7:0] b;
      output ack;
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            put_bit(b[i]);
         get_bit(ack);
      end
   endtask
   task get_byte;
      input last;
      output [7:0] b;
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            get_bit(b[i]);
         put_bit(last);
      end
   endtask
   task wr_reg;
      input [7:0] p;
      input [15:0] d;
      input full;
      output ok;
      reg a;
      begin
         start_cond;
         put_byte({ADDR, 1'b0}, a);
         ok = ~a;
         put_byte(p, a);
         ok = ok & ~a;
         if (full) begin
            put_byte(d[15:8], a);
            ok = ok & ~a;
            put_byte(d[7:0], a);
            ok = ok & ~a;
         end
         stop_cond;
      end
   endtask
   task rd_cur;
      input [6:0] addr;
      output [15:0] d;
      output ack;
      begin
         d = 16'h0000;
         start_cond;
         put_byte({addr, 1'b1}, ack);
         if (ack == 1'b0) begin
            get_byte(1'b0, d[15:8]);
            get_byte(1'b1, d[7:0]);
         end
         stop_cond;
      end
   endtask
endmodule

// ===== testbench.sv
// Purpose: register access, alert and sleep tests of the register bank
// Assumes: short conversion counts so periods fit a short run
// Notes: rate code 10 gives a 60 clock conversion period here
`timescale 1ns/100ps
module testbench;
   reg clk_sys;
   reg rst;
   reg ce;
   reg [15:0] temp_sample;
   wire sda_out;
   wire sda_oe_n;
   wire alert_out;
   wire alert_oe_n;
   wire scl;
   wire host_sda_oe_n;
   wire sda_line;
   reg [15:0] rd;
   reg ok;
   integer n_fail;
   integer n_checks;
   integer i;
   assign sda_line = (sda_oe_n | sda_out) & host_sda_oe_n;
   tsrb_top #(.CONV_CYCLES(32'd20), .PERIOD_Q(32'd100), .PERIOD_1(32'd80), .PERIOD_4(32'd60),
      .PERIOD_8(32'd40)) uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .temp_sample(temp_sample), .alert_out(alert_out),
      .alert_oe_n(alert_oe_n));
   tsrb_host_model host (.clk_sys(clk_sys), .sda_in(sda_line), .scl(scl), .sda_oe_n(host_sda_oe_n));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task test_done;
      begin
         if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task check;
      input [15:0] got;
      input [15:0] exp;
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task check1;
      input got;
      input exp;
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
         end
      end
   endtask
   task wr;
      input [1:0] p;
      input [15:0] d;
      begin
         host.wr_reg({6'h00, p}, d, 1'b1, ok);
         check1(ok, 1'b1);
      end
   endtask
   task rd_chk;
      input [1:0] p;
      input [15:0] exp;
      begin
         host.wr_reg({6'h00, p}, 16'h0000, 1'b0, ok);
         host.rd_cur(7'h40, rd, ok);
         check(rd, exp);
      end
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_fail = n_fail + 1;
      test_done;
   end
   initial begin
      n_fail = 0;
      n_checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      temp_sample = 16'h0123;
      repeat (6) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      host.tick(8);
      check1(alert_oe_n, 1'b1);
      rd_chk(2'h1, 16'h40a0);
      rd_chk(2'h2, 16'h0800);
      rd_chk(2'h3, 16'h1000);
      rd_chk(2'h0, 16'h0123);
      // upper pointer bits must not disturb the selection
      host.wr_reg(8'hfd, 16'h0000, 1'b0, ok);
      host.rd_cur(7'h40, rd, ok);
      check(rd, 16'h40a0);
      host.rd_cur(7'h41, rd, ok);
      check1(ok, 1'b1);
      wr(2'h0, 16'h0000);
      rd_chk(2'h0, 16'h0123);
      wr(2'h2, 16'ha5c3);
      wr(2'h3, 16'h5a3c);
      rd_chk(2'h2, 16'ha5c3);
      rd_chk(2'h3, 16'h5a3c);
      wr(2'h2, 16'h0800);
      wr(2'h3, 16'h1000);
      for (i = 0; i < 4; i = i + 1) begin
         wr(2'h1, 16'h203f | {i[1:0], 6'h00} | {i[1:0], 11'h000});
         rd_chk(2'h1, 16'h4020 | {i[1:0], 6'h00} | {i[1:0], 11'h000});
      end
      wr(2'h1, 16'hffff);
      rd_chk(2'h1, 16'h5fc0);
      check1(alert_oe_n, 1'b0);
      wr(2'h1, 16'h1880);
      temp_sample = 16'h2000;
      host.tick(150);
      check1(alert_oe_n, 1'b1);
      host.tick(100);
      check1(alert_oe_n, 1'b0);
      rd_chk(2'h1, 16'h5880);
      temp_sample = 16'h0100;
      host.tick(150);
      check1(alert_oe_n, 1'b0);
      host.tick(100);
      check1(alert_oe_n, 1'b1);
      rd_chk(2'h1, 16'h58a0);
      // interrupt style holds the pin until a read, unlike comparator style
      wr(2'h1, 16'h0280);
      temp_sample = 16'h2000;
      host.tick(100);
      check1(alert_oe_n, 1'b0);
      host.rd_cur(7'h40, rd, ok);
      check(rd, 16'h4280);
      check1(alert_oe_n, 1'b1);
      temp_sample = 16'h0100;
      ce = 1'b0;
      host.tick(40);
      ce = 1'b1;
      wr(2'h1, 16'h0180);
      temp_sample = 16'h0777;
      host.tick(200);
      rd_chk(2'h0, 16'h0100);
      wr(2'h1, 16'h0080);
      host.tick(30);
      rd_chk(2'h0, 16'h0777);
      test_done;
   end
endmodule
